/* File: rtl/ttm_regs.svh */
// Purpose: Offsets, field positions, reset values and capability masks of the trap trigger block.
// Assumes: 32-bit register width, two triggers behind the index select register.
// Notes: Definitions only.
`ifndef TTM_REGS_SVH
`define TTM_REGS_SVH

`define TTM_ADDR_SELECT 12'h7a0
`define TTM_ADDR_CONFIG 12'h7a1
`define TTM_ADDR_MASK 12'h7a2

`define TTM_TYPE_IRQ 4'h4
`define TTM_TYPE_EXC 4'h5
`define TTM_TYPE_NONE 4'h0

`define TTM_POS_TYPE 28
`define TTM_POS_DMODE 27
`define TTM_POS_HIT 26
`define TTM_POS_VS 12
`define TTM_POS_VU 11
`define TTM_POS_NMI 10
`define TTM_POS_M 9
`define TTM_POS_S 7
`define TTM_POS_U 6
`define TTM_ACTION_W 6

`define TTM_RST_TYPE 4'h0
`define TTM_RST_ACTION 6'h00
`define TTM_RST_MASK 32'h0000_0000

// Interrupt codes 1,3,5,7,9,11 and a subset of exception codes are backed by flops.
`define TTM_IRQ_SUPPORTED 32'h0000_0aaa
`define TTM_EXC_SUPPORTED 32'h0000_b1ff

// Hart capabilities: S and U present, no virtualization.
`define TTM_HAS_S 1'b1
`define TTM_HAS_U 1'b1
`define TTM_HAS_H 1'b0

`define TTM_PRIV_U 2'h0
`define TTM_PRIV_S 2'h1
`define TTM_PRIV_M 2'h3

`endif

/* File: rtl/ttm_pkg.sv */
// Purpose: Shared types of the trap trigger block.
// Assumes: 32-bit register width.
// Notes: Constants live in ttm_regs.svh.
package ttm_pkg;
    typedef logic [31:0] ttm_word_t;
    typedef logic [3:0] ttm_type_t;
    typedef logic [1:0] ttm_priv_t;
    typedef logic [4:0] ttm_code_t;
endpackage : ttm_pkg

/* File: rtl/ttm_mode_filter.sv */
// Purpose: Decides whether a trap's source privilege mode is enabled for a trigger.
// Assumes: Mode enables are already legalised by the caller.
// Notes: Purely combinational.
`timescale 1ns/100ps
module ttm_mode_filter (
    input wire logic m_en_i,
    input wire logic s_en_i,
    input wire logic u_en_i,
    input wire logic vs_en_i,
    input wire logic vu_en_i,
    input wire ttm_pkg::ttm_priv_t priv_i,
    input wire logic virt_i,
    output logic mode_ok_o
);
    always_comb begin
        case (priv_i)
            2'h3: mode_ok_o = m_en_i;
            2'h1: mode_ok_o = virt_i ? vs_en_i : s_en_i;
            2'h0: mode_ok_o = virt_i ? vu_en_i : u_en_i;
            default: mode_ok_o = 1'b0;
        endcase
    end
endmodule : ttm_mode_filter

/* File: rtl/ttm_cause_match.sv */
// Purpose: Matches a taken trap against one trigger's type and cause mask.
// Assumes: The mask holds only supported bits, so codes above 31 never reach it.
// Notes: Purely combinational.
`timescale 1ns/100ps
module ttm_cause_match (
    input wire ttm_pkg::ttm_type_t type_i,
    input wire ttm_pkg::ttm_word_t mask_i,
    input wire logic nmi_en_i,
    input wire logic irq_i,
    input wire logic nmi_i,
    input wire ttm_pkg::ttm_code_t code_i,
    output logic cause_ok_o
);
    `include "ttm_regs.svh"
    always_comb begin
        cause_ok_o = 1'b0;
        if (type_i == `TTM_TYPE_IRQ && irq_i) begin
            cause_ok_o = nmi_i ? nmi_en_i : mask_i[code_i];
        end else if (type_i == `TTM_TYPE_EXC && !irq_i) begin
            cause_ok_o = mask_i[code_i];
        end
    end
endmodule : ttm_cause_match

/* File: rtl/ttm_trigger_unit.sv */
// Purpose: Trap-entry trigger module with two triggers seen through an index select register.
// Assumes: CSR port reads return data one cycle later; the hart holds the handler's first
//          instruction until the cycle after trap_valid_i, when fire_o is known.
// Notes:
// Operation
// - Type 4 shows interrupt-trigger layout.
// - Type 5 shows exception-trigger layout.
// - Config access reaches selected trigger; common resets.
// - Interrupt matches when its mask bit set.
// - Enabled NMI fires if mode enabled.
// - Interrupt codes above 31 unselectable.
// - Partial interrupt mask; software reads back.
// - Fire after trap, before handler.
// - Action zero: breakpoint trap, zero tval.
// - Extra context conditions also required.
// - Hardware sets hit; software writes freely.
// - Interrupt mode enables; missing modes zero.
// - Exception matches when cause bit set.
// - Exception mode enables; missing modes zero.
// - Exception word field positions fixed.
// - Six-bit action field; fields reset zero.
// - Exception codes above 31 unselectable.
// - Partial exception mask; software reads back.
`timescale 1ns/100ps
module ttm_trigger_unit (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic csr_re_i,
    input wire logic csr_we_i,
    input wire logic [11:0] csr_addr_i,
    input wire ttm_pkg::ttm_word_t csr_wdata_i,
    input wire logic debug_mode_i,
    input wire logic trap_valid_i,
    input wire logic trap_irq_i,
    input wire logic trap_nmi_i,
    input wire ttm_pkg::ttm_code_t trap_code_i,
    input wire ttm_pkg::ttm_priv_t trap_priv_i,
    input wire logic trap_virt_i,
    input wire logic ctx_match_i,
    output ttm_pkg::ttm_word_t csr_rdata_o,
    output logic fire_o,
    output logic [5:0] fire_action_o,
    output logic tval_zero_o
);
    `include "ttm_regs.svh"

    localparam int NTRIG = 2;

    logic sel_q;
    ttm_pkg::ttm_type_t type_q [NTRIG];
    logic dmode_q [NTRIG];
    logic hit_q [NTRIG];
    logic nmi_q [NTRIG];
    logic m_q [NTRIG];
    logic s_q [NTRIG];
    logic u_q [NTRIG];
    logic [5:0] action_q [NTRIG];
    ttm_pkg::ttm_word_t mask_q [NTRIG];
    logic [NTRIG-1:0] match;
    logic any_match;
    logic [5:0] match_action;
    logic wr_cfg;
    logic wr_mask;

    ////////////////////////////////////////////////////////////////////////////////
    // Register views.

    function automatic ttm_pkg::ttm_word_t supported_mask(input ttm_pkg::ttm_type_t t);
        supported_mask = (t == `TTM_TYPE_IRQ) ? `TTM_IRQ_SUPPORTED :
                         (t == `TTM_TYPE_EXC) ? `TTM_EXC_SUPPORTED : 32'h0000_0000;
    endfunction : supported_mask

    function automatic ttm_pkg::ttm_word_t config_word(input int i);
        config_word = 32'h0000_0000;
        config_word[`TTM_POS_TYPE +: 4] = type_q[i];
        if (type_q[i] != `TTM_TYPE_NONE) begin
            config_word[`TTM_POS_DMODE] = dmode_q[i];
            config_word[`TTM_POS_HIT] = hit_q[i];
            config_word[`TTM_POS_VS] = `TTM_HAS_H & 1'b0;
            config_word[`TTM_POS_VU] = `TTM_HAS_H & 1'b0;
            // Bit 10 only carries the NMI enable in the interrupt view; it is zero otherwise.
            config_word[`TTM_POS_NMI] = (type_q[i] == `TTM_TYPE_IRQ) & nmi_q[i];
            config_word[`TTM_POS_M] = m_q[i];
            config_word[`TTM_POS_S] = s_q[i];
            config_word[`TTM_POS_U] = u_q[i];
            config_word[`TTM_ACTION_W-1:0] = action_q[i];
        end
    endfunction : config_word

    assign wr_cfg = csr_we_i && csr_addr_i == `TTM_ADDR_CONFIG;
    assign wr_mask = csr_we_i && csr_addr_i == `TTM_ADDR_MASK;

    ////////////////////////////////////////////////////////////////////////////////
    // Trigger index select.

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sel_q <= 1'b0;
        end else if (csr_we_i && csr_addr_i == `TTM_ADDR_SELECT) begin
            sel_q <= csr_wdata_i[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-trigger configuration; every trigger shares the same reset values.

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < NTRIG; i++) begin
                type_q[i] <= `TTM_RST_TYPE;
                dmode_q[i] <= 1'b0;
                nmi_q[i] <= 1'b0;
                m_q[i] <= 1'b0;
                s_q[i] <= 1'b0;
                u_q[i] <= 1'b0;
                action_q[i] <= `TTM_RST_ACTION;
                mask_q[i] <= `TTM_RST_MASK;
            end
        end else begin
            for (int i = 0; i < NTRIG; i++) begin
                if (wr_cfg && sel_q == i[0] && (!dmode_q[i] || debug_mode_i)) begin
                    // Unsupported types fall back to none rather than keeping a stale layout.
                    if (csr_wdata_i[`TTM_POS_TYPE +: 4] == `TTM_TYPE_IRQ ||
                        csr_wdata_i[`TTM_POS_TYPE +: 4] == `TTM_TYPE_EXC) begin
                        type_q[i] <= csr_wdata_i[`TTM_POS_TYPE +: 4];
                    end else begin
                        type_q[i] <= `TTM_TYPE_NONE;
                    end
                    dmode_q[i] <= csr_wdata_i[`TTM_POS_DMODE] & debug_mode_i;
                    nmi_q[i] <= csr_wdata_i[`TTM_POS_NMI];
                    m_q[i] <= csr_wdata_i[`TTM_POS_M];
                    s_q[i] <= csr_wdata_i[`TTM_POS_S] & `TTM_HAS_S;
                    u_q[i] <= csr_wdata_i[`TTM_POS_U] & `TTM_HAS_U;
                    action_q[i] <= csr_wdata_i[`TTM_ACTION_W-1:0];
                    mask_q[i] <= mask_q[i] & supported_mask(csr_wdata_i[`TTM_POS_TYPE +: 4]);
                end else if (wr_mask && sel_q == i[0] && (!dmode_q[i] || debug_mode_i)) begin
                    // Only 32 mask bits exist, so codes above 31 cannot be chosen.
                    mask_q[i] <= csr_wdata_i & supported_mask(type_q[i]);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Hit flags; a hardware set in the same cycle as a software write wins.

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < NTRIG; i++) begin
                hit_q[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < NTRIG; i++) begin
                if (match[i]) begin
                    hit_q[i] <= 1'b1;
                end else if (wr_cfg && sel_q == i[0] && (!dmode_q[i] || debug_mode_i)) begin
                    hit_q[i] <= csr_wdata_i[`TTM_POS_HIT];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Trap matching.

    for (genvar g = 0; g < NTRIG; g++) begin : g_trig
        logic mode_ok;
        logic cause_ok;
        ttm_mode_filter u_mode (
            .m_en_i(m_q[g]),
            .s_en_i(s_q[g]),
            .u_en_i(u_q[g]),
            .vs_en_i(1'b0),
            .vu_en_i(1'b0),
            .priv_i(trap_priv_i),
            .virt_i(trap_virt_i),
            .mode_ok_o(mode_ok)
        );
        ttm_cause_match u_cause (
            .type_i(type_q[g]),
            .mask_i(mask_q[g]),
            .nmi_en_i(nmi_q[g]),
            .irq_i(trap_irq_i),
            .nmi_i(trap_nmi_i),
            .code_i(trap_code_i),
            .cause_ok_o(cause_ok)
        );
        assign match[g] = trap_valid_i && mode_ok && cause_ok && ctx_match_i;
    end

    assign any_match = |match;

    always_comb begin
        match_action = `TTM_RST_ACTION;
        for (int i = NTRIG - 1; i >= 0; i--) begin
            if (match[i]) begin
                match_action = action_q[i];
            end
        end
    end

    // Firing is registered: the hart sees it in the cycle after trap entry, ahead of the handler.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fire_o <= 1'b0;
            fire_action_o <= `TTM_RST_ACTION;
            tval_zero_o <= 1'b0;
        end else begin
            fire_o <= any_match;
            fire_action_o <= match_action;
            tval_zero_o <= any_match && match_action == 6'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read port; unmapped addresses read as zero.

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            csr_rdata_o <= 32'h0000_0000;
        end else if (csr_re_i) begin
            case (csr_addr_i)
                `TTM_ADDR_SELECT: csr_rdata_o <= {31'h0000_0000, sel_q};
                `TTM_ADDR_CONFIG: csr_rdata_o <= config_word(int'(sel_q));
                `TTM_ADDR_MASK: csr_rdata_o <= mask_q[sel_q];
                default: csr_rdata_o <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_fire_follows_trap;
        @(posedge sys_clk_i) disable iff (!rst_b_i) fire_o |-> $past(trap_valid_i);
    endproperty
    a_fire_follows_trap: assert property (p_fire_follows_trap) else $error("fire without trap");

    property p_match_fires;
        @(posedge sys_clk_i) disable iff (!rst_b_i) any_match |=> fire_o;
    endproperty
    a_match_fires: assert property (p_match_fires) else $error("match did not fire");

    property p_nmi_fires;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (trap_valid_i && trap_irq_i && trap_nmi_i && ctx_match_i && type_q[0] == `TTM_TYPE_IRQ
             && nmi_q[0] && trap_priv_i == `TTM_PRIV_M && m_q[0]) |-> ##1 fire_o;
    endproperty
    a_nmi_fires: assert property (p_nmi_fires) else $error("nmi missed");

    property p_exc_fires;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (trap_valid_i && !trap_irq_i && ctx_match_i && type_q[0] == `TTM_TYPE_EXC
             && mask_q[0][trap_code_i] && trap_priv_i == `TTM_PRIV_M && m_q[0]) |=> fire_o;
    endproperty
    a_exc_fires: assert property (p_exc_fires) else $error("exception missed");

    property p_ctx_blocks;
        @(posedge sys_clk_i) disable iff (!rst_b_i) !ctx_match_i |=> !fire_o;
    endproperty
    a_ctx_blocks: assert property (p_ctx_blocks) else $error("fired without context");

    property p_hit_set;
        @(posedge sys_clk_i) disable iff (!rst_b_i) match[0] |=> hit_q[0];
    endproperty
    a_hit_set: assert property (p_hit_set) else $error("hit not set");

    property p_tval_zero;
        @(posedge sys_clk_i) disable iff (!rst_b_i) fire_o && fire_action_o == 6'h00 |-> tval_zero_o;
    endproperty
    a_tval_zero: assert property (p_tval_zero) else $error("tval not zeroed");

    property p_mask_legal;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            $past(csr_re_i && csr_addr_i == `TTM_ADDR_MASK) |->
            (csr_rdata_o & ~(`TTM_IRQ_SUPPORTED | `TTM_EXC_SUPPORTED)) == 32'h0000_0000;
    endproperty
    a_mask_legal: assert property (p_mask_legal) else $error("unsupported mask bit");

    property p_virt_zero;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            $past(csr_re_i && csr_addr_i == `TTM_ADDR_CONFIG) |-> csr_rdata_o[12:11] == 2'h0;
    endproperty
    a_virt_zero: assert property (p_virt_zero) else $error("virtual enable set");

    property p_type_legal;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            $past(csr_re_i && csr_addr_i == `TTM_ADDR_CONFIG) |->
            csr_rdata_o[31:28] inside {4'h0, 4'h4, 4'h5};
    endproperty
    a_type_legal: assert property (p_type_legal) else $error("illegal type read");

    property p_reset_zero;
        @(posedge sys_clk_i) $rose(rst_b_i) |-> action_q[0] == 6'h00 && !hit_q[0] && mask_q[1] == 32'h0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

    // A maskable interrupt whose trigger 0 mask bit is clear must never match trigger 0.
    property p_irq_needs_mask;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (trap_valid_i && trap_irq_i && !trap_nmi_i && !mask_q[0][trap_code_i]) |-> !match[0];
    endproperty
    a_irq_needs_mask: assert property (p_irq_needs_mask) else $error("masked interrupt matched");

    // A trap from plain U mode with trigger 0's U enable clear never matches trigger 0, whatever its cause.
    property p_mode_off_quiet;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
            (trap_valid_i && trap_priv_i == `TTM_PRIV_U && !trap_virt_i && !u_q[0]) |-> !match[0];
    endproperty
    a_mode_off_quiet: assert property (p_mode_off_quiet) else $error("disabled mode matched");

endmodule : ttm_trigger_unit

/* File: tb/ttm_hart_model.sv */
// Purpose: Hart trap-entry side that offers one trap at a time to the trigger block.
// Assumes: Called from the bench 1 ns after a rising clock edge.
// Notes: Code, privilege, irq and nmi fields are scrambled between traps so that stale values can never match by luck.
`timescale 1ns/100ps
module ttm_hart_model (
    input wire logic sys_clk_i,
    output logic trap_valid_o,
    output logic trap_irq_o,
    output logic trap_nmi_o,
    output ttm_pkg::ttm_code_t trap_code_o,
    output ttm_pkg::ttm_priv_t trap_priv_o,
    output logic trap_virt_o,
    output logic ctx_match_o
);
    initial begin
        trap_valid_o = 1'b0;
        trap_irq_o = 1'b0;
        trap_nmi_o = 1'b0;
        trap_code_o = 5'h00;
        trap_priv_o = 2'h0;
        trap_virt_o = 1'b0;
        ctx_match_o = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // A trap is held across exactly one rising edge and the caller withdraws it with idle.
    task automatic take_trap(input logic irq, input logic nmi, input ttm_pkg::ttm_code_t code,
                             input ttm_pkg::ttm_priv_t priv, input logic virt, input logic ctx);
        trap_valid_o = 1'b1;
        trap_irq_o = irq;
        trap_nmi_o = nmi;
        trap_code_o = code;
        trap_priv_o = priv;
        trap_virt_o = virt;
        ctx_match_o = ctx;
        @(posedge sys_clk_i);
        #1;
    endtask : take_trap

    task automatic idle();
        trap_valid_o = 1'b0;
        trap_code_o = ~trap_code_o;
        trap_priv_o = ~trap_priv_o;
        trap_irq_o = ~trap_irq_o;
        trap_nmi_o = ~trap_nmi_o;
    endtask : idle
endmodule : ttm_hart_model

/* File: tb/tb.sv */
// Purpose: Self-checking bench of the trap trigger unit.
// Assumes: Reads answer one cycle after the strobe; fire outputs one cycle after the trap.
// Notes: Debug mode is raised only by the guard test at the end.
`timescale 1ns/100ps
`include "ttm_regs.svh"
module tb;
    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] msk;
        logic irq;
        logic nmi;
        logic [4:0] code;
        logic [1:0] priv;
        logic virt;
        logic ctx;
        logic fire;
        logic [5:0] act;
    } ttm_row_s;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic csr_re_i = 1'b0;
    logic csr_we_i = 1'b0;
    logic [11:0] csr_addr_i = 12'h000;
    ttm_pkg::ttm_word_t csr_wdata_i = 32'h0000_0000;
    logic debug_mode_i = 1'b0;
    logic tv, ti, tn, tvi, cm;
    ttm_pkg::ttm_code_t tc;
    ttm_pkg::ttm_priv_t tp;
    ttm_pkg::ttm_word_t csr_rdata_o;
    logic fire_o;
    logic [5:0] fire_action_o;
    logic tval_zero_o;
    wire ttm_pkg::ttm_word_t fire_w = {24'h000000, tval_zero_o, fire_action_o, fire_o};
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;
    ttm_row_s rows [13];

    always #50 sys_clk_i = ~sys_clk_i;

    ttm_hart_model hart (.sys_clk_i(sys_clk_i), .trap_valid_o(tv), .trap_irq_o(ti), .trap_nmi_o(tn),
        .trap_code_o(tc), .trap_priv_o(tp), .trap_virt_o(tvi), .ctx_match_o(cm));

    ttm_trigger_unit dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .csr_re_i(csr_re_i),
        .csr_we_i(csr_we_i), .csr_addr_i(csr_addr_i), .csr_wdata_i(csr_wdata_i), .debug_mode_i(debug_mode_i),
        .trap_valid_i(tv), .trap_irq_i(ti), .trap_nmi_i(tn), .trap_code_i(tc), .trap_priv_i(tp),
        .trap_virt_i(tvi), .ctx_match_i(cm), .csr_rdata_o(csr_rdata_o), .fire_o(fire_o),
        .fire_action_o(fire_action_o), .tval_zero_o(tval_zero_o));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input ttm_pkg::ttm_word_t got, input ttm_pkg::ttm_word_t exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input ttm_pkg::ttm_word_t d);
        csr_we_i = 1'b1;
        csr_addr_i = a;
        csr_wdata_i = d;
        @(posedge sys_clk_i);
        #1;
        csr_we_i = 1'b0;
        // One quiet edge keeps a following call from re-raising the strobe in the same time step.
        @(posedge sys_clk_i);
        #1;
    endtask : wr

    task automatic rd(input logic [11:0] a);
        csr_re_i = 1'b1;
        csr_addr_i = a;
        @(posedge sys_clk_i);
        #1;
        csr_re_i = 1'b0;
        @(posedge sys_clk_i);
        #1;
    endtask : rd

    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rows = '{
            '{32'h4000_0200, 32'hffff_ffff, 1'b1, 1'b0, 5'h07, 2'h3, 1'b0, 1'b1, 1'b1, 6'h00},
            '{32'h4000_0200, 32'hffff_ffff, 1'b1, 1'b0, 5'h02, 2'h3, 1'b0, 1'b1, 1'b0, 6'h00},
            '{32'h4000_0200, 32'hffff_ffff, 1'b1, 1'b0, 5'h07, 2'h0, 1'b0, 1'b1, 1'b0, 6'h00},
            '{32'h4000_007f, 32'hffff_ffff, 1'b1, 1'b0, 5'h07, 2'h0, 1'b0, 1'b1, 1'b1, 6'h3f},
            '{32'h4000_0080, 32'hffff_ffff, 1'b1, 1'b0, 5'h05, 2'h1, 1'b0, 1'b1, 1'b1, 6'h00},
            '{32'h4000_0600, 32'h0000_0000, 1'b1, 1'b1, 5'h00, 2'h3, 1'b0, 1'b1, 1'b1, 6'h00},
            '{32'h4000_0200, 32'h0000_0000, 1'b1, 1'b1, 5'h00, 2'h3, 1'b0, 1'b1, 1'b0, 6'h00},
            '{32'h4000_0200, 32'hffff_ffff, 1'b1, 1'b0, 5'h07, 2'h3, 1'b0, 1'b0, 1'b0, 6'h00},
            '{32'h4000_02c0, 32'hffff_ffff, 1'b1, 1'b0, 5'h07, 2'h1, 1'b1, 1'b1, 1'b0, 6'h00},
            '{32'h5000_0045, 32'hffff_ffff, 1'b0, 1'b0, 5'h02, 2'h0, 1'b0, 1'b1, 1'b1, 6'h05},
            '{32'h5000_0045, 32'hffff_ffff, 1'b0, 1'b0, 5'h09, 2'h0, 1'b0, 1'b1, 1'b0, 6'h00},
            '{32'h5000_0045, 32'hffff_ffff, 1'b1, 1'b0, 5'h02, 2'h0, 1'b0, 1'b1, 1'b0, 6'h00},
            '{32'h4000_0200, 32'hffff_ffff, 1'b0, 1'b0, 5'h07, 2'h3, 1'b0, 1'b1, 1'b0, 6'h00}};
        repeat (8) @(posedge sys_clk_i);
        #1;
        rst_b_i = 1'b1;
        // Action is only defined while fire is high, so it is masked out on quiet rows.
        for (int i = 0; i < 13; i++) begin
            wr(`TTM_ADDR_CONFIG, rows[i].cfg);
            wr(`TTM_ADDR_MASK, rows[i].msk);
            hart.take_trap(rows[i].irq, rows[i].nmi, rows[i].code, rows[i].priv, rows[i].virt, rows[i].ctx);
            chk(fire_w & (fire_o ? 32'h0000_00ff : 32'h0000_0001),
                {24'h000000, rows[i].fire && rows[i].act == 6'h00, rows[i].act, rows[i].fire});
            hart.idle();
        end
        $display("test table done");
        rst_b_i = 1'b0;
        @(posedge sys_clk_i);
        #1;
        rst_b_i = 1'b1;
        rd(`TTM_ADDR_CONFIG);
        chk(csr_rdata_o, 32'h0000_0000);
        rd(`TTM_ADDR_MASK);
        chk(csr_rdata_o, 32'h0000_0000);
        rd(`TTM_ADDR_SELECT);
        chk(csr_rdata_o, 32'h0000_0000);
        $display("test reset done");
        wr(`TTM_ADDR_CONFIG, 32'h5000_1ec5);
        rd(`TTM_ADDR_CONFIG);
        chk(csr_rdata_o, 32'h5000_02c5);
        wr(`TTM_ADDR_MASK, 32'hffff_ffff);
        rd(`TTM_ADDR_MASK);
        chk(csr_rdata_o, 32'h0000_b1ff);
        wr(`TTM_ADDR_CONFIG, 32'h4000_1e00);
        rd(`TTM_ADDR_CONFIG);
        chk(csr_rdata_o, 32'h4000_0600);
        wr(`TTM_ADDR_MASK, 32'hffff_ffff);
        rd(`TTM_ADDR_MASK);
        chk(csr_rdata_o, 32'h0000_0aaa);
        wr(`TTM_ADDR_CONFIG, 32'h3000_0200);
        rd(`TTM_ADDR_CONFIG);
        chk(csr_rdata_o, 32'h0000_0000);
        $display("test legalise done");
        wr(`TTM_ADDR_CONFIG, 32'h4000_0200);
        wr(`TTM_ADDR_MASK, 32'h0000_0080);
        hart.take_trap(1'b1, 1'b0, 5'h07, 2'h3, 1'b0, 1'b1);
        chk(fire_w, 32'h0000_0081);
        hart.take_trap(1'b1, 1'b0, 5'h07, 2'h3, 1'b0, 1'b1);
        chk(fire_w, 32'h0000_0081);
        hart.idle();
        rd(`TTM_ADDR_CONFIG);
        chk(csr_rdata_o, 32'h4400_0200);
        wr(`TTM_ADDR_CONFIG, 32'h4000_0200);
        rd(`TTM_ADDR_CONFIG);
        chk(csr_rdata_o, 32'h4000_0200);
        $display("test hit done");
        wr(`TTM_ADDR_SELECT, 32'h0000_0001);
        rd(`TTM_ADDR_CONFIG);
        chk(csr_rdata_o, 32'h0000_0000);
        wr(`TTM_ADDR_CONFIG, 32'h4000_0205);
        wr(`TTM_ADDR_MASK, 32'h0000_0080);
        hart.take_trap(1'b1, 1'b0, 5'h07, 2'h3, 1'b0, 1'b1);
        chk(fire_w, 32'h0000_0081);
        hart.idle();
        rd(`TTM_ADDR_CONFIG);
        chk(csr_rdata_o, 32'h4400_0205);
        wr(`TTM_ADDR_SELECT, 32'h0000_0000);
        rd(`TTM_ADDR_CONFIG);
        chk(csr_rdata_o, 32'h4400_0200);
        $display("test select done");
        debug_mode_i = 1'b1;
        wr(`TTM_ADDR_CONFIG, 32'h4800_0200);
        debug_mode_i = 1'b0;
        rd(`TTM_ADDR_CONFIG);
        chk(csr_rdata_o, 32'h4800_0200);
        wr(`TTM_ADDR_CONFIG, 32'h4000_0200);
        rd(`TTM_ADDR_CONFIG);
        chk(csr_rdata_o, 32'h4800_0200);
        wr(`TTM_ADDR_MASK, 32'h0000_0000);
        rd(`TTM_ADDR_MASK);
        chk(csr_rdata_o, 32'h0000_0080);
        $display("test guard done");
        print_verdict();
    end
endmodule : tb
